// ### hw/cms_switcher.sv
// Clock mode switcher: APB slave holding the control, ready, configuration and wait registers,
// and the sequencer that moves the machine clock between four sources.
// Assumes oscillator stabilization is timed on pclk; clock muxing downstream obeys the select outputs.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "cms_defs.svh"
module cms_switcher #(
  parameter int MCR_WAIT = `CMS_MCR_WAIT_CYC,
  parameter int SCR_WAIT = `CMS_SCR_WAIT_CYC,
  parameter int SUB_WAIT = `CMS_SUB_WAIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_watchdog_on,
  output cms_pkg::cms_mode_t machine_clk_sel,
  output logic main_osc_run,
  output logic subclock_run,
  output logic sub_rc_run,
  output logic main_rc_run,
  output logic timebase_run,
  output logic watch_from_sub_rc,
  output logic timebase_standby_ok,
  output logic watch_standby_ok
);
  import cms_pkg::*;

  cms_state_s_t r;
  cms_state_s_t next_r;

  // Main wait: 2^n - 2 cycles, codes below 2 collapse to zero
  function automatic logic [15:0] main_wait(input logic [3:0] code);
    logic [4:0] n;
    n = (code < 4'h2) ? 5'd1 : 5'({1'b0, code} - 5'd1);
    main_wait = 16'((17'd1 << n) - 17'd2);
  endfunction

  function automatic logic [15:0] wait_for(input cms_mode_t m, input logic [3:0] code);
    case (m)
      cms_sub_rc: wait_for = 16'(SCR_WAIT);
      cms_subclk: wait_for = 16'(SUB_WAIT);
      cms_main_rc: wait_for = 16'(MCR_WAIT);
      cms_main_osc: wait_for = main_wait(code);
      default: wait_for = 16'(MCR_WAIT);
    endcase
  endfunction

  // Mode code and ready-bit position differ, so map between them
  function automatic logic [1:0] rdy_bit(input cms_mode_t m);
    case (m)
      cms_sub_rc: rdy_bit = 2'(`CMS_RDY_SCR);
      cms_subclk: rdy_bit = 2'(`CMS_RDY_SUB);
      cms_main_rc: rdy_bit = 2'(`CMS_RDY_MCR);
      cms_main_osc: rdy_bit = 2'(`CMS_RDY_MAIN);
      default: rdy_bit = 2'(`CMS_RDY_MCR);
    endcase
  endfunction

  logic wr;
  logic rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    cms_mode_t wsel;
    logic main_dis;
    logic sub_dis;
    logic [1:0] idx;
    next_r = r;
    // Watchdog strap comes from slow logic elsewhere; counts once stages two and three agree
    next_r.wd_sync = {r.wd_sync[1:0], hw_watchdog_on};
    if (r.wd_sync[1] == r.wd_sync[2]) begin
      next_r.wd_on = r.wd_sync[2];
    end
    wsel = cms_mode_t'(pwdata[`CMS_SEL_HI:`CMS_SEL_LO]);
    main_dis = r.cfg[`CMS_CFG_MAIN_DIS];
    sub_dis = r.cfg[`CMS_CFG_SUB_DIS];
    idx = rdy_bit(r.sel);
    if (wr && paddr == `CMS_ADDR_CONTROL) begin
      // Monitor bits of pwdata are dropped here
      if (!((wsel == cms_main_osc && main_dis) || (wsel == cms_subclk && sub_dis))) begin
        next_r.sel = wsel;
      end
      if (pwdata[`CMS_BIT_SUB_EN] || (r.sel != cms_subclk && r.mon != cms_subclk)) begin
        if (!(pwdata[`CMS_BIT_SUB_EN] && sub_dis)) begin
          next_r.sub_en = pwdata[`CMS_BIT_SUB_EN];
        end
      end
      if (pwdata[`CMS_BIT_MAIN_EN] || (r.sel != cms_main_osc && r.mon != cms_main_osc)) begin
        if (!(pwdata[`CMS_BIT_MAIN_EN] && (!r.mon[1] || main_dis))) begin
          next_r.main_en = pwdata[`CMS_BIT_MAIN_EN];
        end
      end
      if (pwdata[`CMS_BIT_SCR_EN] || (r.sel != cms_sub_rc && r.mon != cms_sub_rc)) begin
        next_r.scr_en = pwdata[`CMS_BIT_SCR_EN];
      end
      if (pwdata[`CMS_BIT_MCR_EN] || (r.sel != cms_main_rc && r.mon != cms_main_rc)) begin
        if (!(pwdata[`CMS_BIT_MCR_EN] && !r.mon[1])) begin
          next_r.mcr_en = pwdata[`CMS_BIT_MCR_EN];
        end
      end
    end
    if (wr && paddr == `CMS_ADDR_CONFIG) begin
      next_r.cfg = pwdata[7:0];
    end
    if (wr && paddr == `CMS_ADDR_WAIT) begin
      next_r.waitsel = pwdata[7:0];
    end
    // Forcing by select follows the stored or new select value
    case (next_r.sel)
      cms_subclk: next_r.sub_en = 1'b1;
      cms_main_osc: next_r.main_en = 1'b1;
      cms_sub_rc: next_r.scr_en = 1'b1;
      cms_main_rc: next_r.mcr_en = 1'b1;
      default: next_r.mcr_en = next_r.mcr_en;
    endcase
    if (r.wd_on) begin
      next_r.scr_en = 1'b1;
    end
    if (next_r.cfg[`CMS_CFG_SUB_DIS] && next_r.sel != cms_subclk) begin
      next_r.sub_en = 1'b0;
    end
    case (r.st)
      cms_st_boot: begin
        // Both CR oscillators time out in parallel; count covers the longer
        if (r.cnt != 16'h0000) begin
          next_r.cnt = 16'(r.cnt - 16'd1);
        end else begin
          next_r.st = cms_st_run;
          next_r.rdy[`CMS_RDY_MCR] = 1'b1;
          next_r.rdy[`CMS_RDY_SCR] = 1'b1;
          next_r.run[`CMS_RDY_MCR] = 1'b1;
          next_r.run[`CMS_RDY_SCR] = 1'b1;
        end
      end
      cms_st_run: begin
        if (r.sel != r.mon) begin
          if (r.rdy[idx] && r.run[idx]) begin
            next_r.mon = r.sel;
          end else begin
            next_r.st = cms_st_wait;
            next_r.cnt = wait_for(r.sel, r.waitsel[3:0]);
            next_r.run[idx] = 1'b1;
          end
        end
      end
      cms_st_wait: begin
        if (r.cnt != 16'h0000) begin
          next_r.cnt = 16'(r.cnt - 16'd1);
        end else begin
          next_r.rdy[idx] = 1'b1;
          next_r.mon = r.sel;
          next_r.st = cms_st_run;
        end
      end
      default: next_r.st = cms_st_run;
    endcase
    // Leaving a main-side mode clears its enable
    if (r.mon == cms_main_osc && next_r.mon != cms_main_osc) begin
      next_r.main_en = 1'b0;
    end
    if (r.mon == cms_main_rc && next_r.mon != cms_main_rc) begin
      next_r.mcr_en = 1'b0;
    end
    // Low-speed modes stop both fast oscillators, whichever was left enabled
    if (r.mon[1] && !next_r.mon[1]) begin
      next_r.main_en = 1'b0;
      next_r.mcr_en = 1'b0;
    end
    // Clearing an oscillator's enable bit also drops its ready and run flags, except during its own wait
    for (int i = 0; i < 4; i++) begin
      logic en;
      en = (i == `CMS_RDY_SCR) ? next_r.scr_en : (i == `CMS_RDY_MCR) ? next_r.mcr_en :
           (i == `CMS_RDY_MAIN) ? next_r.main_en : next_r.sub_en;
      if (!en && !(r.st == cms_st_wait && 2'(i) == idx)) begin
        next_r.rdy[i] = 1'b0;
        next_r.run[i] = 1'b0;
      end
    end
    next_r.prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        `CMS_ADDR_CONTROL: next_r.prdata = {24'h00_0000, 2'(r.mon), 2'(r.sel), r.sub_en, r.main_en,
                                            r.scr_en, r.mcr_en};
        `CMS_ADDR_STANDBY: next_r.prdata = {28'h000_0000, r.rdy[`CMS_RDY_SUB], r.rdy[`CMS_RDY_SCR],
                                            r.rdy[`CMS_RDY_MCR], r.rdy[`CMS_RDY_MAIN]};
        `CMS_ADDR_CONFIG: next_r.prdata = {24'h00_0000, r.cfg};
        `CMS_ADDR_WAIT: next_r.prdata = {24'h00_0000, r.waitsel};
        default: next_r.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.st <= cms_st_boot;
      r.sel <= cms_main_rc;
      r.mon <= cms_main_rc;
      r.sub_en <= 1'b0;
      r.main_en <= 1'b0;
      r.scr_en <= 1'b1;
      r.mcr_en <= 1'b1;
      r.rdy <= 4'h0;
      r.run <= 4'h0;
      r.cnt <= 16'(SCR_WAIT > MCR_WAIT ? SCR_WAIT : MCR_WAIT);
      r.cfg <= `CMS_CFG_RESET;
      r.waitsel <= `CMS_WAIT_RESET;
      r.prdata <= 32'h0000_0000;
      r.wd_sync <= 3'b000;
      r.wd_on <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // Machine clock follows the monitor; change only at the switch cycle
  assign machine_clk_sel = r.mon;
  assign main_osc_run = r.main_en;
  assign subclock_run = r.sub_en;
  assign sub_rc_run = r.scr_en;
  assign main_rc_run = r.mcr_en;
  assign timebase_run = r.mon[1];
  assign watch_from_sub_rc = (r.mon == cms_sub_rc) || !r.sub_en;
  // Standby gating is advisory; the standby sequencer uses these
  assign timebase_standby_ok = r.mon[1] && (r.mon == r.sel) && (r.st == cms_st_run);
  assign watch_standby_ok = !r.mon[1] && (r.mon == r.sel) && (r.st == cms_st_run);
endmodule

// ### hw/cms_defs.svh
// Constants for the clock mode switcher: register offsets, field positions, reset values, wait times.
// Assumes the includer runs on pclk at 10 MHz; oscillator clocks are seen only as enables here.
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH
`define CMS_ADDR_CONTROL 12'h000
`define CMS_ADDR_STANDBY 12'h004
`define CMS_ADDR_CONFIG 12'h008
`define CMS_ADDR_WAIT 12'h00C
`define CMS_MON_HI 7
`define CMS_MON_LO 6
`define CMS_SEL_HI 5
`define CMS_SEL_LO 4
`define CMS_BIT_SUB_EN 3
`define CMS_BIT_MAIN_EN 2
`define CMS_BIT_SCR_EN 1
`define CMS_BIT_MCR_EN 0
`define CMS_RDY_SCR 2
`define CMS_RDY_MCR 1
`define CMS_RDY_MAIN 0
`define CMS_RDY_SUB 3
`define CMS_CFG_MAIN_DIS 0
`define CMS_CFG_SUB_DIS 1
`define CMS_CFG_RESET 8'h00
`define CMS_WAIT_RESET 8'hFF
`define CMS_MCR_WAIT_NS 20000
`define CMS_SCR_WAIT_NS 100000
`define CMS_SUB_WAIT_CYC 1000
`define CMS_CLK_NS 100
`define CMS_MCR_WAIT_CYC ((`CMS_MCR_WAIT_NS + `CMS_CLK_NS - 1) / `CMS_CLK_NS)
`define CMS_SCR_WAIT_CYC ((`CMS_SCR_WAIT_NS + `CMS_CLK_NS - 1) / `CMS_CLK_NS)
`endif

// ### hw/cms_pkg.sv
// Types for the clock mode switcher.
// Assumes cms_defs.svh supplies all numeric constants.
package cms_pkg;
  typedef enum logic [1:0] {
    cms_sub_rc = 2'b00,
    cms_subclk = 2'b01,
    cms_main_rc = 2'b10,
    cms_main_osc = 2'b11
  } cms_mode_t;
  typedef enum logic [1:0] {
    cms_st_boot = 2'b00,
    cms_st_run = 2'b01,
    cms_st_wait = 2'b10
  } cms_state_t;
  typedef struct packed {
    cms_state_t st;
    cms_mode_t sel;
    cms_mode_t mon;
    logic sub_en;
    logic main_en;
    logic scr_en;
    logic mcr_en;
    logic [3:0] rdy;
    logic [3:0] run;
    logic [15:0] cnt;
    logic [7:0] cfg;
    logic [7:0] waitsel;
    logic [31:0] prdata;
    logic [2:0] wd_sync;
    logic wd_on;
  } cms_state_s_t;
endpackage

// ### test/cms_switcher_chk.sv
// Assertions on the clock mode switcher outputs.
// Assumes binding to cms_switcher; single pclk domain.
`timescale 1ns/100ps
module cms_switcher_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire cms_pkg::cms_mode_t machine_clk_sel,
  input wire logic main_osc_run,
  input wire logic subclock_run,
  input wire logic sub_rc_run,
  input wire logic main_rc_run,
  input wire logic timebase_run,
  input wire logic watch_from_sub_rc,
  input wire logic timebase_standby_ok,
  input wire logic watch_standby_ok
);
  import cms_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_timebase_follows_mode: assert property (timebase_run == machine_clk_sel[1])
    else $error("time-base run disagrees with mode");
  a_main_mode_osc: assert property (machine_clk_sel == cms_main_osc |-> main_osc_run)
    else $error("main mode without main oscillator");
  // Checked at entry only: a later select of a fast mode restarts its oscillator during the wait
  a_low_mode_fast_off: assert property (!machine_clk_sel[1] && $past(machine_clk_sel[1])
    |-> !main_osc_run && !main_rc_run)
    else $error("fast oscillator left running in low-speed mode");
  a_mcr_mode_osc: assert property (machine_clk_sel == cms_main_rc |-> main_rc_run)
    else $error("main CR mode without main CR oscillator");
  a_sub_mode_osc: assert property (machine_clk_sel == cms_subclk |-> subclock_run)
    else $error("subclock mode without subclock");
  a_scr_mode_osc: assert property (machine_clk_sel == cms_sub_rc
    |-> sub_rc_run && watch_from_sub_rc)
    else $error("sub-CR mode without sub-CR clock");
  a_tbt_standby_fast: assert property (timebase_standby_ok |-> machine_clk_sel[1])
    else $error("time-base standby allowed in low-speed mode");
  a_watch_standby_slow: assert property (watch_standby_ok |-> !machine_clk_sel[1])
    else $error("watch standby allowed in fast mode");
  a_reset_main_cr: assert property ($rose(presetn) |-> (machine_clk_sel == cms_main_rc) [*3])
    else $error("mode not main CR after reset");
  c_main: cover property (machine_clk_sel == cms_main_osc);
  c_sub: cover property (machine_clk_sel == cms_subclk);
  c_sub_rc: cover property (machine_clk_sel == cms_sub_rc);
endmodule
bind cms_switcher cms_switcher_chk cms_switcher_chk_inst (.pclk(pclk), .presetn(presetn),
  .machine_clk_sel(machine_clk_sel), .main_osc_run(main_osc_run), .subclock_run(subclock_run),
  .sub_rc_run(sub_rc_run), .main_rc_run(main_rc_run), .timebase_run(timebase_run),
  .watch_from_sub_rc(watch_from_sub_rc), .timebase_standby_ok(timebase_standby_ok),
  .watch_standby_ok(watch_standby_ok));

// ### test/cms_switcher_test.sv
// Self-checking bench for the clock mode switcher over APB.
// Assumes short oscillator waits (4 cycles) and main wait code 3, which gives a 2-cycle main wait.
`timescale 1ns/100ps
`include "cms_defs.svh"
module cms_switcher_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wdog = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready;
  cms_pkg::cms_mode_t mode;
  logic wsrc;
  int mismatches = 0, tests_run = 0;
  cms_switcher #(.MCR_WAIT(4), .SCR_WAIT(4), .SUB_WAIT(4)) cms_switcher_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .hw_watchdog_on(wdog), .machine_clk_sel(mode), .main_osc_run(),
    .subclock_run(), .sub_rc_run(), .main_rc_run(), .timebase_run(), .watch_from_sub_rc(wsrc),
    .timebase_standby_ok(), .watch_standby_ok());
  always #50 pclk = ~pclk;
  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Setup then access; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a stalled access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, r, {24'h00_0000, e});
  endtask
  // Bounded poll of the monitor field, then full compare
  task automatic wait_mode(input logic [7:0] e, input int lim);
    int n;
    n = 0;
    apb(1'b0, `CMS_ADDR_CONTROL, 32'h0000_0000);
    while ((r[7:6] !== e[7:6] || r[7:6] !== r[5:4]) && n < lim) begin
      apb(1'b0, `CMS_ADDR_CONTROL, 32'h0000_0000);
      n++;
    end
    chk("control", r, {24'h00_0000, e});
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd("control", `CMS_ADDR_CONTROL, 8'hA3);
    repeat (10) @(posedge pclk);
    rd("ready", `CMS_ADDR_STANDBY, 8'h06);
    rd("wait", `CMS_ADDR_WAIT, 8'hFF);
    wr(12'h010, 8'hFF);
    rd("unmapped", 12'h010, 8'h00);
    wr(`CMS_ADDR_CONTROL, 8'hE3);
    rd("control", `CMS_ADDR_CONTROL, 8'hA3);
    wr(`CMS_ADDR_CONFIG, 8'h03);
    wr(`CMS_ADDR_CONTROL, 8'hB7);
    rd("control", `CMS_ADDR_CONTROL, 8'hA3);
    wr(`CMS_ADDR_CONTROL, 8'h9B);
    rd("control", `CMS_ADDR_CONTROL, 8'hA3);
    wr(`CMS_ADDR_CONFIG, 8'h00);
    wr(`CMS_ADDR_WAIT, 8'h03);
    wr(`CMS_ADDR_CONTROL, 8'hB3);
    wait_mode(8'hF6, 30);
    rd("ready", `CMS_ADDR_STANDBY, 8'h05);
    chk("mode", mode, 2'b11);
    wr(`CMS_ADDR_CONTROL, 8'h12);
    wait_mode(8'h5A, 30);
    wr(`CMS_ADDR_CONTROL, 8'h15);
    rd("control", `CMS_ADDR_CONTROL, 8'h58);
    rd("ready", `CMS_ADDR_STANDBY, 8'h08);
    wr(`CMS_ADDR_CONTROL, 8'h08);
    wait_mode(8'h0A, 30);
    chk("watch source", wsrc, 1'b1);
    wr(`CMS_ADDR_CONTROL, 8'h2B);
    wait_mode(8'hAB, 30);
    wdog <= 1'b1;
    repeat (5) @(posedge pclk);
    wr(`CMS_ADDR_CONTROL, 8'h29);
    rd("control", `CMS_ADDR_CONTROL, 8'hAB);
    wdog <= 1'b0;
    repeat (5) @(posedge pclk);
    // Sub-CR still running and ready, so no stabilization wait
    wr(`CMS_ADDR_CONTROL, 8'h0B);
    wait_mode(8'h0A, 1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("control", `CMS_ADDR_CONTROL, 8'hA3);
    test_done();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    mismatches++;
    test_done();
  end
endmodule
